// ==== core/bpc_pkg.sv ====
// Constants for the two-channel block output port controller.
// Assumes one 100 MHz clock and a plain word-indexed register port.
package bpc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SRQ_SETTLE_NS = 40;
    localparam logic [2:0] HOLD_CYCLES = 3'((SRQ_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Register index: bit 3 picks the channel, bits 1:0 the register
    localparam logic [3:0] CH_SEL_MASK = 4'h8;
    localparam logic [3:0] RESERVED_MASK = 4'h4;
    localparam logic [1:0] REG_ASSIGN = 2'h0;
    localparam logic [1:0] REG_CTRL = 2'h1;
    localparam logic [1:0] REG_LOAD_SEL = 2'h2;
    localparam logic [1:0] REG_LOAD_DATA = 2'h3;

    // Control register write bits
    localparam int unsigned CTL_SET_CONTROL = 0;
    localparam int unsigned CTL_CLEAR_FLAG = 1;
    localparam int unsigned CTL_CLEAR_CONTROL = 2;
    localparam int unsigned CTL_SET_FLAG = 3;
    // Control register read bits
    localparam int unsigned STAT_CONTROL = 0;
    localparam int unsigned STAT_FLAG = 1;

    // Assignment word fields
    localparam int unsigned ASG_STC_BIT = 15;
    localparam int unsigned ASG_CLC_BIT = 13;
    localparam int unsigned SC_W = 6;
    // Address control word: top bit is direction, 1 = into memory
    localparam int unsigned DIR_BIT = 15;
    localparam int unsigned ADDR_W = 15;

    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_LAST = 16'hffff;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [2:0] TRAP_CH1 = 3'h6;
    localparam logic [2:0] TRAP_CH2 = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_GRANT = 2'b01,
        ST_DATA = 2'b10,
        ST_HOLD = 2'b11
    } cycle_state_t;
endpackage

// ==== core/bpc_channel.sv ====
// One channel's control words, control and completion flag.
// Assumes single-cycle write strobes and a one-cycle step per moved word.
`timescale 1ns/10ps
module bpc_channel (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Software writes
    input wire logic i_wr_assign,
    input wire logic i_wr_ctrl,
    input wire logic i_wr_load_sel,
    input wire logic i_wr_load_data,
    input wire logic [15:0] i_wdata,
    // Word moved by the cycle engine
    input wire logic i_step,
    // State
    output logic [15:0] o_assign,
    output logic o_dir_in,
    output logic [bpc_pkg::ADDR_W-1:0] o_addr,
    output logic [15:0] o_count,
    output logic o_load_sel,
    output logic o_control,
    output logic o_flag
);
    logic last_step;
    assign last_step = i_step && (o_count == bpc_pkg::COUNT_LAST);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_assign <= bpc_pkg::WORD_ZERO;
        end else if (i_wr_assign) begin
            o_assign <= i_wdata;
        end
    end

    // Load-select bit 0 clear selects the address, set selects the count
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_load_sel <= 1'b0;
        end else if (i_wr_load_sel) begin
            o_load_sel <= i_wdata[0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_addr <= '0;
            o_dir_in <= 1'b0;
        end else if (i_wr_load_data && !o_load_sel) begin
            o_addr <= i_wdata[bpc_pkg::ADDR_W-1:0];
            o_dir_in <= i_wdata[bpc_pkg::DIR_BIT];
        end else if (i_step) begin
            o_addr <= o_addr + bpc_pkg::ADDR_ONE;
        end
    end

    // Full 16-bit negative count, counts up to zero
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_count <= bpc_pkg::WORD_ZERO;
        end else if (i_wr_load_data && o_load_sel) begin
            o_count <= i_wdata;
        end else if (i_step) begin
            o_count <= o_count + bpc_pkg::COUNT_ONE;
        end
    end

    // Completion and software set both drop control
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_control <= 1'b0;
        end else if (last_step || (i_wr_ctrl && i_wdata[bpc_pkg::CTL_SET_FLAG])) begin
            o_control <= 1'b0;
        end else if (i_wr_ctrl && i_wdata[bpc_pkg::CTL_SET_CONTROL]) begin
            o_control <= 1'b1;
        end else if (i_wr_ctrl && i_wdata[bpc_pkg::CTL_CLEAR_CONTROL]) begin
            o_control <= 1'b0;
        end
    end

    // Hardware set beats a software clear in the same cycle
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flag <= 1'b0;
        end else if (last_step || (i_wr_ctrl && i_wdata[bpc_pkg::CTL_SET_FLAG])) begin
            o_flag <= 1'b1;
        end else if (i_wr_ctrl && i_wdata[bpc_pkg::CTL_CLEAR_FLAG]) begin
            o_flag <= 1'b0;
        end
    end
endmodule

// ==== core/block_output_port_controller.sv ====
// Two-channel block output port controller: moves memory words to an
// interface, one stolen cycle per service request, counting to zero.
// Assumes memory answers a read one cycle after o_mem_rd, and service
// requests come from outside the clock domain.
// Behaviour
// - each transfer cycle moves exactly one word; device latches it before next request
// - an active request from the assigned interface starts one single-word cycle
// - cycles continue until the word count reaches zero
// - block completion sets the channel flag, testable by software
// - with interrupts enabled, a set flag interrupts to trap cell six or seven
// - controller issues set-control; interface turns it into a device command
// - optional set-control goes out before the data word is presented
// - request may stand early; no cycle runs until the channel is enabled
// - set control and clear flag enables the channel, sampling the request
// - each cycle begins with set-control option and clear-flag to the interface
// - assignment word gives select code, per-word set-control, last-word clear-control
// - address word gives direction and start address
// - count word holds the negative number of words
// - assignment bit fifteen enables set-control each cycle; zero gives none
// - sixteen-bit count, whole words, no byte packing
// - software setting the flag aborts a running block
`timescale 1ns/10ps
module block_output_port_controller (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Memory read port
    output logic o_mem_rd,
    output logic [bpc_pkg::ADDR_W-1:0] o_mem_addr,
    input wire logic [15:0] i_mem_rdata,
    // Interface bus
    input wire logic [63:0] i_service_request,
    output logic [bpc_pkg::SC_W-1:0] o_io_sc,
    output logic o_io_set_control,
    output logic o_io_clear_flag,
    output logic o_io_clear_control,
    output logic o_io_wr,
    output logic [15:0] o_io_data,
    // Processor interrupt system
    input wire logic i_int_sys_en,
    output logic o_irq,
    output logic [2:0] o_irq_vector,
    output logic [1:0] o_chan_flag
);
    bpc_pkg::cycle_state_t state;
    logic [63:0] srq_meta;
    logic [63:0] srq_sync;
    logic [1:0] wr_assign, wr_ctrl, wr_sel, wr_data, step, want;
    logic [15:0] asg [2];
    logic [bpc_pkg::ADDR_W-1:0] addr [2];
    logic [15:0] count [2];
    logic [1:0] dir_in, load_sel, control, flag;
    logic cur;
    logic next_cur;
    logic [2:0] hold_cnt;
    logic was_last;
    logic [1:0] reg_sel;
    logic ch;

    assign ch = (i_addr & bpc_pkg::CH_SEL_MASK) != 4'h0;
    assign reg_sel = i_addr[1:0];

    // Request lines cross in from the interface clock domain
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            srq_meta <= '0;
            srq_sync <= '0;
        end else begin
            srq_meta <= i_service_request;
            srq_sync <= srq_meta;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_ch
        logic mine;
        assign mine = i_wr && (ch == 1'(g)) && ((i_addr & bpc_pkg::RESERVED_MASK) == 4'h0);
        assign wr_assign[g] = mine && (reg_sel == bpc_pkg::REG_ASSIGN);
        assign wr_ctrl[g] = mine && (reg_sel == bpc_pkg::REG_CTRL);
        assign wr_sel[g] = mine && (reg_sel == bpc_pkg::REG_LOAD_SEL);
        assign wr_data[g] = mine && (reg_sel == bpc_pkg::REG_LOAD_DATA);
        assign step[g] = (state == bpc_pkg::ST_DATA) && (cur == 1'(g));
        // Only enabled output channels whose assigned request is up
        assign want[g] = control[g] && !flag[g] && !dir_in[g]
            && srq_sync[asg[g][bpc_pkg::SC_W-1:0]];

        bpc_channel u_chan (
            .i_ref_clk(i_ref_clk),
            .i_rst(i_rst),
            .i_wr_assign(wr_assign[g]),
            .i_wr_ctrl(wr_ctrl[g]),
            .i_wr_load_sel(wr_sel[g]),
            .i_wr_load_data(wr_data[g]),
            .i_wdata(i_wdata),
            .i_step(step[g]),
            .o_assign(asg[g]),
            .o_dir_in(dir_in[g]),
            .o_addr(addr[g]),
            .o_count(count[g]),
            .o_load_sel(load_sel[g]),
            .o_control(control[g]),
            .o_flag(flag[g])
        );
    end

    // Channel 1 wins when both ask in the same cycle
    always_comb begin
        next_cur = cur;
        if (want[0]) begin
            next_cur = 1'b0;
        end else if (want[1]) begin
            next_cur = 1'b1;
        end
    end

    // Hold covers the interface clearing its flag and the two-stage sync
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= bpc_pkg::ST_IDLE;
            cur <= 1'b0;
            hold_cnt <= 3'h0;
        end else begin
            case (state)
                bpc_pkg::ST_IDLE: begin
                    if (want != 2'b00) begin
                        state <= bpc_pkg::ST_GRANT;
                        cur <= next_cur;
                    end
                end
                bpc_pkg::ST_GRANT: begin
                    state <= bpc_pkg::ST_DATA;
                end
                bpc_pkg::ST_DATA: begin
                    state <= bpc_pkg::ST_HOLD;
                    hold_cnt <= bpc_pkg::HOLD_CYCLES;
                end
                bpc_pkg::ST_HOLD: begin
                    if (hold_cnt == 3'h0) begin
                        state <= bpc_pkg::ST_IDLE;
                    end else begin
                        hold_cnt <= hold_cnt - 3'h1;
                    end
                end
                default: begin
                    state <= bpc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Cycle start: clear flag, optional set-control, memory read
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mem_rd <= 1'b0;
            o_mem_addr <= '0;
            o_io_sc <= '0;
            o_io_clear_flag <= 1'b0;
            o_io_set_control <= 1'b0;
        end else begin
            o_mem_rd <= (state == bpc_pkg::ST_IDLE) && (want != 2'b00);
            o_io_clear_flag <= (state == bpc_pkg::ST_IDLE) && (want != 2'b00);
            // Set-control leads the data, so the interface must delay the device command
            o_io_set_control <= (state == bpc_pkg::ST_IDLE) && (want != 2'b00)
                && asg[next_cur][bpc_pkg::ASG_STC_BIT];
            if ((state == bpc_pkg::ST_IDLE) && (want != 2'b00)) begin
                o_mem_addr <= addr[next_cur];
                o_io_sc <= asg[next_cur][bpc_pkg::SC_W-1:0];
            end
        end
    end

    // Mid cycle: the word reaches the interface output register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_io_wr <= 1'b0;
            o_io_data <= bpc_pkg::WORD_ZERO;
            o_io_clear_control <= 1'b0;
            was_last <= 1'b0;
        end else begin
            o_io_wr <= (state == bpc_pkg::ST_DATA);
            o_io_clear_control <= (state == bpc_pkg::ST_DATA) && (count[cur] == bpc_pkg::COUNT_LAST)
                && asg[cur][bpc_pkg::ASG_CLC_BIT];
            if (state == bpc_pkg::ST_DATA) begin
                o_io_data <= i_mem_rdata;
                was_last <= count[cur] == bpc_pkg::COUNT_LAST;
            end
        end
    end

    // Completion interrupt; channel 1 vectors first
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
            o_irq_vector <= bpc_pkg::TRAP_CH1;
            o_chan_flag <= 2'b00;
        end else begin
            o_chan_flag <= flag;
            o_irq <= i_int_sys_en && (flag != 2'b00);
            o_irq_vector <= flag[0] ? bpc_pkg::TRAP_CH1 : bpc_pkg::TRAP_CH2;
        end
    end

    // Reading the load-data register returns the live word count
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= bpc_pkg::WORD_ZERO;
        end else if (i_rd && ((i_addr & bpc_pkg::RESERVED_MASK) == 4'h0)) begin
            case (reg_sel)
                bpc_pkg::REG_ASSIGN: o_rdata <= asg[ch];
                bpc_pkg::REG_CTRL: o_rdata <= {14'h0, flag[ch], control[ch]};
                bpc_pkg::REG_LOAD_SEL: o_rdata <= {15'h0, load_sel[ch]};
                bpc_pkg::REG_LOAD_DATA: o_rdata <= count[ch];
                default: o_rdata <= bpc_pkg::WORD_ZERO;
            endcase
        end else begin
            o_rdata <= bpc_pkg::WORD_ZERO;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_clf_with_read: assert property (o_io_clear_flag |-> o_mem_rd
        && o_io_sc == asg[cur][bpc_pkg::SC_W-1:0]) else $error("clear-flag without cycle start");
    a_stc_option: assert property (o_mem_rd |-> o_io_set_control == asg[cur][bpc_pkg::ASG_STC_BIT])
        else $error("set-control does not follow option bit");
    a_stc_before_data: assert property (o_io_set_control |-> !o_io_wr ##2 o_io_wr)
        else $error("data not presented after set-control");
    a_one_word: assert property (o_io_wr |=> !o_io_wr [*4])
        else $error("more than one word in a cycle");
    a_read_to_write: assert property (o_mem_rd |-> ##2 (o_io_wr && o_io_data == $past(i_mem_rdata)))
        else $error("read word not forwarded");
    a_enable_needed: assert property (o_mem_rd |-> $past(want != 2'b00))
        else $error("cycle started without enabled request");
    a_last_sets_flag: assert property (o_io_wr && was_last |-> flag[cur] && !control[cur])
        else $error("flag not set at count zero");
    a_irq_follow: assert property (i_int_sys_en && flag != 2'b00 |=> o_irq)
        else $error("completion interrupt missing");
    a_count_step: assert property (step[0] |=> count[0] == $past(count[0]) + bpc_pkg::COUNT_ONE
        && addr[0] == $past(addr[0]) + bpc_pkg::ADDR_ONE)
        else $error("count or address not advanced");
    a_abort_stops: assert property (wr_ctrl[0] && i_wdata[bpc_pkg::CTL_SET_FLAG] |=> !control[0] && flag[0])
        else $error("software set flag did not abort");
    a_clc_last: assert property (o_io_clear_control |-> o_io_wr && was_last)
        else $error("clear-control not on last word");

    // Transfer routing and held outputs
    a_sc_held: assert property (o_io_wr |-> o_io_sc == $past(o_io_sc, 2))
        else $error("select code moved mid cycle");
    a_data_held: assert property (!o_io_wr |-> $stable(o_io_data))
        else $error("data changed without a word");
    a_addr_source: assert property (o_mem_rd |-> o_mem_addr == addr[cur])
        else $error("wrong memory address");
    a_grant_order: assert property (o_mem_rd |-> state == bpc_pkg::ST_GRANT
        ##1 state == bpc_pkg::ST_DATA) else $error("cycle steps out of order");
    a_output_only: assert property (o_io_wr |-> !dir_in[cur] && state == bpc_pkg::ST_HOLD)
        else $error("word moved on an input channel");
    a_idle_disabled: assert property (state == bpc_pkg::ST_IDLE && control == 2'b00 |=> !o_mem_rd)
        else $error("cycle on a disabled channel");
    a_clc_due: assert property (o_io_wr && was_last && asg[cur][bpc_pkg::ASG_CLC_BIT]
        |-> o_io_clear_control) else $error("clear-control missing");

    // Completion flag and interrupt
    a_irq_off: assert property (!i_int_sys_en |=> !o_irq)
        else $error("interrupt while system disabled");
    a_irq_none: assert property (flag == 2'b00 |=> !o_irq)
        else $error("interrupt without a flag");
    a_vector_ch1: assert property (flag[0] |=> o_irq_vector == bpc_pkg::TRAP_CH1)
        else $error("wrong trap cell for channel 1");
    a_vector_ch2: assert property (flag == 2'b10 |=> o_irq_vector == bpc_pkg::TRAP_CH2)
        else $error("wrong trap cell for channel 2");
    a_flag_copy: assert property (o_chan_flag == $past(flag))
        else $error("channel flag copy lags");
    a_last_done_ch2: assert property (step[1] && count[1] == bpc_pkg::COUNT_LAST
        |=> flag[1] && !control[1]) else $error("channel 2 flag not set at count zero");

    // Register port
    a_rdata_zero: assert property (!$past(i_rd) |-> o_rdata == bpc_pkg::WORD_ZERO)
        else $error("read data outside its cycle");
    a_load_count: assert property (wr_data[0] && load_sel[0] |=> count[0] == $past(i_wdata))
        else $error("count word not loaded");
    a_load_addr: assert property (wr_data[0] && !load_sel[0]
        |=> addr[0] == $past(i_wdata[bpc_pkg::ADDR_W-1:0])) else $error("address word not loaded");
    a_count_step2: assert property (step[1] |=> count[1] == $past(count[1]) + bpc_pkg::COUNT_ONE
        && addr[1] == $past(addr[1]) + bpc_pkg::ADDR_ONE) else $error("channel 2 count or address not advanced");

    c_word_moved: cover property (o_io_wr);
    c_block_done: cover property (o_io_wr && was_last);
    c_both_channels: cover property (want == 2'b11 ##1 o_mem_rd);
    c_irq_ch2: cover property (o_irq && o_irq_vector == bpc_pkg::TRAP_CH2);
    c_abort: cover property (wr_ctrl[0] && i_wdata[bpc_pkg::CTL_SET_FLAG] && control[0]);
endmodule

// ==== testbench/io_card_model.sv ====
// Behavioural interface card and output device on the controller's far side.
// Assumes the controller's pulses are one clock wide and its select code is held.
`timescale 1ns/10ps
module io_card_model #(
    parameter logic [5:0] SC = 6'h09
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Controller side
    input wire logic [5:0] i_io_sc,
    input wire logic i_io_set_control,
    input wire logic i_io_clear_flag,
    input wire logic i_io_clear_control,
    input wire logic i_io_wr,
    input wire logic [15:0] i_io_data,
    // Software commands and device speed, delay at least 1
    input wire logic i_sw_set_flag,
    input wire logic i_sw_clear_control,
    input wire logic [7:0] i_delay,
    // Request and device view
    output logic o_service_request,
    output logic [15:0] o_latched,
    output logic [15:0] o_latch_cnt
);
    logic control;
    logic fire;
    logic hit;
    logic [15:0] out_reg;
    logic [7:0] busy;

    assign hit = i_io_sc == SC;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            control <= 1'b0;
            fire <= 1'b0;
            out_reg <= 16'h0000;
            busy <= 8'h00;
            o_service_request <= 1'b0;
            o_latched <= 16'h0000;
            o_latch_cnt <= 16'h0000;
        end else begin
            if (hit && i_io_wr) begin
                out_reg <= i_io_data;
            end
            // Timing flip-flop: command only at the end of the transfer cycle
            fire <= hit && i_io_wr && control;
            if (fire) begin
                o_latched <= out_reg;
                o_latch_cnt <= o_latch_cnt + 16'h0001;
                busy <= i_delay;
                control <= 1'b0;
            end
            if (busy != 8'h00) begin
                busy <= busy - 8'h01;
            end
            if (busy == 8'h01 || i_sw_set_flag) begin
                o_service_request <= 1'b1;
            end
            if (hit && i_io_clear_flag) begin
                o_service_request <= 1'b0;
            end
            if (hit && i_io_set_control) begin
                control <= 1'b1;
            end
            if ((hit && i_io_clear_control) || i_sw_clear_control) begin
                control <= 1'b0;
            end
        end
    end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the block output port controller.
// Assumes the card model above and a memory that answers one cycle after a read.
`timescale 1ns/10ps
module tb_top;
    localparam logic [5:0] CARD_SC = 6'h09;
    logic i_ref_clk, i_rst, i_wr, i_rd, o_mem_rd, o_irq, i_int_sys_en, service_request;
    logic o_io_set_control, o_io_clear_flag, o_io_clear_control, o_io_wr;
    logic sw_set_flag, sw_clear_control;
    logic [3:0] i_addr;
    logic [15:0] i_wdata, o_rdata, mem_rdata, o_io_data, latched, latch_cnt, d;
    logic [14:0] o_mem_addr;
    logic [5:0] o_io_sc;
    logic [2:0] o_irq_vector;
    logic [1:0] o_chan_flag;
    logic [7:0] delay;
    int errors, tests_run, rd_cnt, stc_cnt, clf_cnt, clc_cnt, rd0, stc0, clf0, clc0;

    block_output_port_controller block_output_port_controller_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .i_mem_rdata(mem_rdata),
        .i_service_request({63'h0, service_request} << CARD_SC), .o_io_sc(o_io_sc),
        .o_io_set_control(o_io_set_control), .o_io_clear_flag(o_io_clear_flag),
        .o_io_clear_control(o_io_clear_control), .o_io_wr(o_io_wr), .o_io_data(o_io_data),
        .i_int_sys_en(i_int_sys_en), .o_irq(o_irq), .o_irq_vector(o_irq_vector), .o_chan_flag(o_chan_flag));
    io_card_model #(.SC(CARD_SC)) io_card_model_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_io_sc(o_io_sc),
        .i_io_set_control(o_io_set_control), .i_io_clear_flag(o_io_clear_flag),
        .i_io_clear_control(o_io_clear_control), .i_io_wr(o_io_wr), .i_io_data(o_io_data),
        .i_sw_set_flag(sw_set_flag), .i_sw_clear_control(sw_clear_control), .i_delay(delay),
        .o_service_request(service_request), .o_latched(latched), .o_latch_cnt(latch_cnt));

    function automatic logic [15:0] memw(input logic [14:0] a);
        return {1'b1, a} ^ 16'h3c5a;
    endfunction

    // Memory drives junk outside its answer cycle
    always @(posedge i_ref_clk) begin
        mem_rdata <= i_rst ? 16'h0000 : (o_mem_rd ? memw(o_mem_addr) : ~mem_rdata);
        if (o_mem_rd === 1'b1) rd_cnt++;
        if (o_io_sc === CARD_SC && o_io_clear_flag === 1'b1) clf_cnt++;
        if (o_io_sc === CARD_SC && o_io_set_control === 1'b1) stc_cnt++;
        if (o_io_sc === CARD_SC && o_io_clear_control === 1'b1) clc_cnt++;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    task automatic setup(input logic ch, input logic set_control_cmd, input logic [14:0] a, input logic [15:0] n);
        wr({ch, 1'b0, bpc_pkg::REG_ASSIGN}, {set_control_cmd, 1'b0, 1'b1, 7'h00, CARD_SC});
        wr({ch, 1'b0, bpc_pkg::REG_LOAD_SEL}, 16'h0000);
        wr({ch, 1'b0, bpc_pkg::REG_LOAD_DATA}, {1'b0, a});
        wr({ch, 1'b0, bpc_pkg::REG_LOAD_SEL}, 16'h0001);
        wr({ch, 1'b0, bpc_pkg::REG_LOAD_DATA}, -n);
        sw_clear_control <= 1'b1;
        @(posedge i_ref_clk);
        sw_clear_control <= 1'b0;
        sw_set_flag <= 1'b1;
        @(posedge i_ref_clk);
        sw_set_flag <= 1'b0;
        rd0 = rd_cnt;
        stc0 = stc_cnt;
        clf0 = clf_cnt;
        clc0 = clc_cnt;
        repeat (10) @(posedge i_ref_clk);
        check(16'(rd_cnt - rd0), 16'h0000, "cycle before enable");
        wr({ch, 1'b0, bpc_pkg::REG_CTRL}, 16'h0003);
    endtask

    task automatic run_block(input logic ch, input logic set_control_cmd, input logic [14:0] a, input logic [15:0] n,
                             input logic ien);
        logic [15:0] base;
        base = latch_cnt;
        i_int_sys_en <= ien;
        setup(ch, set_control_cmd, a, n);
        for (int k = 0; k < 5000 && o_chan_flag[ch] !== 1'b1; k++) @(posedge i_ref_clk);
        // The last word reaches the device only after the flag shows
        repeat (3) @(posedge i_ref_clk);
        #1;
        check({15'h0, o_chan_flag[ch]}, 16'h0001, "completion flag");
        check(16'(rd_cnt - rd0), n, "memory reads");
        check(16'(clf_cnt - clf0), n, "clear flag pulses");
        check(16'(stc_cnt - stc0), set_control_cmd ? n : 16'h0000, "set control pulses");
        check(16'(clc_cnt - clc0), 16'h0001, "clear control pulses");
        check(latch_cnt - base, set_control_cmd ? n : 16'h0000, "device latches");
        if (set_control_cmd) check(latched, memw(a + 15'(n - 16'h0001)), "last word");
        rd({ch, 1'b0, bpc_pkg::REG_LOAD_DATA}, d);
        check(d, bpc_pkg::WORD_ZERO, "word count");
        rd({ch, 1'b0, bpc_pkg::REG_CTRL}, d);
        check(d, 16'h0002, "status");
        check({12'h0, o_irq, o_irq_vector}, {12'h0, ien, ch ? bpc_pkg::TRAP_CH2 : bpc_pkg::TRAP_CH1},
              "interrupt");
        wr({ch, 1'b0, bpc_pkg::REG_CTRL}, 16'h0006);
        repeat (3) @(posedge i_ref_clk);
        check({15'h0, o_irq}, 16'h0000, "interrupt cleared");
    endtask

    task automatic abort_block();
        int r;
        delay <= 8'd20;
        setup(1'b0, 1'b1, 15'h0100, 16'd20);
        for (int k = 0; k < 2000 && rd_cnt - rd0 < 3; k++) @(posedge i_ref_clk);
        wr({1'b0, 1'b0, bpc_pkg::REG_CTRL}, 16'h0008);
        repeat (40) @(posedge i_ref_clk);
        r = rd_cnt - rd0;
        check(16'(r), 16'h0003, "words before abort");
        repeat (60) @(posedge i_ref_clk);
        check(16'(rd_cnt - rd0), 16'(r), "no cycles after abort");
        rd({1'b0, 1'b0, bpc_pkg::REG_LOAD_DATA}, d);
        check(d, 16'(r - 20), "remaining count");
        rd({1'b0, 1'b0, bpc_pkg::REG_CTRL}, d);
        check(d & 16'h0002, 16'h0002, "abort flag");
        wr({1'b0, 1'b0, bpc_pkg::REG_CTRL}, 16'h0006);
        delay <= 8'd1;
    endtask

    task automatic finish_test();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    initial begin
        #400000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        i_rst = 1'b1;
        {i_wr, i_rd, i_int_sys_en, sw_set_flag, sw_clear_control} = 5'h00;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        delay = 8'd1;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        #1;
        check({10'h0, o_irq, o_irq_vector, o_chan_flag}, {11'h0, bpc_pkg::TRAP_CH1, 2'b00}, "reset");
        rd(4'h4, d);
        check(d, 16'h0000, "reserved read");
        run_block(1'b1, 1'b1, 15'h0080, 16'd50, 1'b1);
        run_block(1'b0, 1'b1, 15'h7ffd, 16'd5, 1'b0);
        run_block(1'b0, 1'b0, 15'h0010, 16'd1, 1'b1);
        abort_block();
        finish_test();
    end
endmodule
